/* File: inc/scpcr_pkg.sv */
// constants, field layouts and types for the sensor configuration register bank
package scpcr_pkg;

    // ------------------------------------------------------------
    // register offsets on the two-wire interface
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MAIN_CFG0 = 8'h02;
    localparam logic [7:0] ADDR_MAIN_CFG1 = 8'h03;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CLK_DIV = 8'h05;

    // ------------------------------------------------------------
    // reset values and writable-bit masks (reserved bits clear)
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MAIN_CFG0 = 8'h00;
    localparam logic [7:0] RST_MAIN_CFG1 = 8'h00;
    localparam logic [7:0] RST_POWER_CTRL = 8'h00;
    localparam logic [7:0] RST_CLK_DIV = 8'h04;
    localparam logic [7:0] MASK_MAIN_CFG0 = 8'h75;
    localparam logic [7:0] MASK_MAIN_CFG1 = 8'hF4;
    localparam logic [7:0] MASK_POWER_CTRL = 8'h0F;
    localparam logic [7:0] MASK_CLK_DIV = 8'hDF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG0_INIT_BUSY = 7;
    localparam int CFG0_SLEEP = 6;
    localparam int CFG0_DEFECT_FIX = 5;
    localparam int CFG0_BLACK_OFF = 4;
    localparam int CFG0_DEFECT_MONO = 2;
    localparam int CFG0_SINGLE_AMP = 0;
    localparam int CFG1_MONO = 7;
    localparam int CFG1_INTERLACE = 6;
    localparam int CFG1_HSKIP = 5;
    localparam int CFG1_VSKIP = 4;
    localparam int CFG1_FOLLOWER = 2;
    localparam int PWR_VIDEO_AMP = 3;
    localparam int PWR_COLOUR_HI = 2;
    localparam int PWR_COLOUR_LO = 1;
    localparam int PWR_CONVERTER = 0;
    localparam int CLK_PUMP_HI = 7;
    localparam int CLK_PUMP_LO = 6;
    localparam int CLK_SENSOR_HI = 4;

    // ------------------------------------------------------------
    // timing and link identity
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // value is arbitrary
    localparam logic [6:0] LINK_DEVICE_ADDR = 7'h3A;

    // ------------------------------------------------------------
    // two-wire slave states
    // ------------------------------------------------------------
    typedef enum logic [8:0]
    {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } scpcr_state_t;

endpackage

/* File: logic/scpcr_clk_div.sv */
// programmable divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module scpcr_clk_div
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // advance and ratio
    input wire logic tickIn,
    input wire logic [4:0] divisor,
    // divided enable
    output logic tickOut
);

    logic [4:0] countQ;
    logic [4:0] lastCount;

    // ratios 0 and 1 both pass every input tick
    assign lastCount = (divisor <= 5'h01) ? 5'h00 : 5'(divisor - 5'h01);

    // ------------------------------------------------------------
    // counter and pulse
    // ------------------------------------------------------------
    // a ratio change mid-count takes effect at the next wrap or at once if below
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            countQ <= 5'h00;
            tickOut <= 1'b0;
        end
        else if (tickIn && countQ >= lastCount)
        begin
            countQ <= 5'h00;
            tickOut <= 1'b1;
        end
        else
        begin
            if (tickIn)
                countQ <= 5'(countQ + 5'h01);
            tickOut <= 1'b0;
        end
    end

endmodule

/* File: logic/scpcr_regs.sv */
// sensor configuration, power and clock register bank behind a two-wire slave
`timescale 1ns/1ps
module scpcr_regs
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // two-wire serial port, open drain data
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // power-down pin
    input wire logic powerDownPin,
    // main configuration zero controls
    output logic initInProgress,
    output logic sensorSleep,
    output logic defectFixEnable,
    output logic blackCompDisable,
    output logic defectFixMonoSelect,
    output logic singleAmpRouting,
    // main configuration one controls
    output logic monoSensorSelect,
    output logic interlaceSelect,
    output logic horizSkipEnable,
    output logic vertSkipEnable,
    output logic syncFollowerSelect,
    // analog power controls
    output logic videoAmpOff,
    output logic [1:0] colourAmpsOff,
    output logic converterOff,
    // derived clock enables
    output logic pumpClockEn,
    output logic sensorClockEn,
    output logic pixelClockEn
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    scpcr_pkg::scpcr_state_t stateQ;
    logic sclPrevQ;
    logic sdaPrevQ;
    logic [7:0] shiftQ;
    logic [3:0] bitCntQ;
    logic readModeQ;
    logic nackQ;
    logic [7:0] ptrQ;
    logic sdaOeQ;
    logic [7:0] cfg0Q;
    logic [7:0] cfg1Q;
    logic [7:0] pwrQ;
    logic [7:0] clkQ;
    logic busyQ;
    logic [15:0] initCntQ;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic wrHit;
    logic [7:0] rdByte;
    logic [4:0] pumpRatio;
    logic [4:0] pixelRatio;

    // ------------------------------------------------------------
    // read decode, shared by address ack and read ack
    // ------------------------------------------------------------
    function automatic logic [7:0] readReg
    (
        input logic [7:0] addr,
        input logic [7:0] cfg0,
        input logic [7:0] cfg1,
        input logic [7:0] pwr,
        input logic [7:0] clk,
        input logic busy
    );
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            scpcr_pkg::ADDR_MAIN_CFG0:
            begin
                val = cfg0 & scpcr_pkg::MASK_MAIN_CFG0;
                val[scpcr_pkg::CFG0_INIT_BUSY] = busy;
            end
            scpcr_pkg::ADDR_MAIN_CFG1: val = cfg1 & scpcr_pkg::MASK_MAIN_CFG1;
            scpcr_pkg::ADDR_POWER_CTRL: val = pwr & scpcr_pkg::MASK_POWER_CTRL;
            scpcr_pkg::ADDR_CLK_DIV: val = clk & scpcr_pkg::MASK_CLK_DIV;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // ------------------------------------------------------------
    // line edge and bus condition detection
    // ------------------------------------------------------------
    // pins are synchronous to clock, so one history flop is enough
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sclPrevQ <= 1'b1;
            sdaPrevQ <= 1'b1;
        end
        else
        begin
            sclPrevQ <= scl;
            sdaPrevQ <= sdaIn;
        end
    end

    assign sclRise = scl && !sclPrevQ;
    assign sclFall = !scl && sclPrevQ;
    assign startSeen = scl && sclPrevQ && sdaPrevQ && !sdaIn;
    assign stopSeen = scl && sclPrevQ && !sdaPrevQ && sdaIn;
    assign rdByte = readReg(ptrQ, cfg0Q, cfg1Q, pwrQ, clkQ, busyQ);
    assign wrHit = sclFall && (stateQ == scpcr_pkg::ST_WDATA) && (bitCntQ == 4'h8);

    // ------------------------------------------------------------
    // two-wire slave sequencer
    // ------------------------------------------------------------
    // address byte, then pointer byte, then data bytes with auto-increment;
    // a read starts at the pointer left by the last write or read
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stateQ <= scpcr_pkg::ST_IDLE;
            shiftQ <= 8'h00;
            bitCntQ <= 4'h0;
            readModeQ <= 1'b0;
            nackQ <= 1'b0;
            ptrQ <= 8'h00;
            sdaOeQ <= 1'b0;
        end
        else if (startSeen)
        begin
            stateQ <= scpcr_pkg::ST_ADDR;
            bitCntQ <= 4'h0;
            sdaOeQ <= 1'b0;
        end
        else if (stopSeen)
        begin
            stateQ <= scpcr_pkg::ST_IDLE;
            sdaOeQ <= 1'b0;
        end
        else if (sclRise)
        begin
            unique case (stateQ)
                scpcr_pkg::ST_ADDR, scpcr_pkg::ST_PTR, scpcr_pkg::ST_WDATA:
                begin
                    shiftQ <= {shiftQ[6:0], sdaIn};
                    bitCntQ <= 4'(bitCntQ + 4'h1);
                end
                scpcr_pkg::ST_RDATA: bitCntQ <= 4'(bitCntQ + 4'h1);
                scpcr_pkg::ST_RACK: nackQ <= sdaIn; // master releases data to stop
                scpcr_pkg::ST_IDLE, scpcr_pkg::ST_ADDR_ACK, scpcr_pkg::ST_PTR_ACK,
                scpcr_pkg::ST_WACK:
                begin
                end
            endcase
        end
        else if (sclFall)
        begin
            unique case (stateQ)
                scpcr_pkg::ST_IDLE:
                begin
                end
                scpcr_pkg::ST_ADDR:
                begin
                    if (bitCntQ == 4'h8)
                    begin
                        if (shiftQ[7:1] == scpcr_pkg::LINK_DEVICE_ADDR)
                        begin
                            stateQ <= scpcr_pkg::ST_ADDR_ACK;
                            readModeQ <= shiftQ[0];
                            sdaOeQ <= 1'b1; // acknowledge by pulling low
                        end
                        else
                            stateQ <= scpcr_pkg::ST_IDLE;
                    end
                end
                scpcr_pkg::ST_ADDR_ACK:
                begin
                    bitCntQ <= 4'h0;
                    if (readModeQ)
                    begin
                        stateQ <= scpcr_pkg::ST_RDATA;
                        shiftQ <= rdByte;
                        sdaOeQ <= !rdByte[7];
                    end
                    else
                    begin
                        stateQ <= scpcr_pkg::ST_PTR;
                        sdaOeQ <= 1'b0;
                    end
                end
                scpcr_pkg::ST_PTR:
                begin
                    if (bitCntQ == 4'h8)
                    begin
                        stateQ <= scpcr_pkg::ST_PTR_ACK;
                        ptrQ <= shiftQ;
                        sdaOeQ <= 1'b1;
                    end
                end
                scpcr_pkg::ST_PTR_ACK, scpcr_pkg::ST_WACK:
                begin
                    stateQ <= scpcr_pkg::ST_WDATA;
                    bitCntQ <= 4'h0;
                    sdaOeQ <= 1'b0;
                end
                scpcr_pkg::ST_WDATA:
                begin
                    if (bitCntQ == 4'h8)
                    begin
                        stateQ <= scpcr_pkg::ST_WACK;
                        ptrQ <= 8'(ptrQ + 8'h01);
                        sdaOeQ <= 1'b1;
                    end
                end
                scpcr_pkg::ST_RDATA:
                begin
                    if (bitCntQ == 4'h8)
                    begin
                        stateQ <= scpcr_pkg::ST_RACK;
                        ptrQ <= 8'(ptrQ + 8'h01);
                        sdaOeQ <= 1'b0;
                    end
                    else
                    begin
                        shiftQ <= {shiftQ[6:0], 1'b0};
                        sdaOeQ <= !shiftQ[6];
                    end
                end
                scpcr_pkg::ST_RACK:
                begin
                    bitCntQ <= 4'h0;
                    if (nackQ)
                        stateQ <= scpcr_pkg::ST_IDLE;
                    else
                    begin
                        stateQ <= scpcr_pkg::ST_RDATA;
                        shiftQ <= rdByte;
                        sdaOeQ <= !rdByte[7];
                    end
                end
            endcase
        end
    end

    // open drain: the line is only ever pulled low
    always_ff @(posedge clock)
    begin
        if (rst)
            sdaOut <= 1'b0;
        else
            sdaOut <= 1'b0;
    end

    assign sdaOe = sdaOeQ;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // only writable bits are stored, so reserved and read-only bits stay zero
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cfg0Q <= scpcr_pkg::RST_MAIN_CFG0;
            cfg1Q <= scpcr_pkg::RST_MAIN_CFG1;
            pwrQ <= scpcr_pkg::RST_POWER_CTRL;
            clkQ <= scpcr_pkg::RST_CLK_DIV;
        end
        else if (wrHit)
        begin
            unique case (ptrQ)
                scpcr_pkg::ADDR_MAIN_CFG0: cfg0Q <= shiftQ & scpcr_pkg::MASK_MAIN_CFG0;
                scpcr_pkg::ADDR_MAIN_CFG1: cfg1Q <= shiftQ & scpcr_pkg::MASK_MAIN_CFG1;
                scpcr_pkg::ADDR_POWER_CTRL: pwrQ <= shiftQ & scpcr_pkg::MASK_POWER_CTRL;
                scpcr_pkg::ADDR_CLK_DIV: clkQ <= shiftQ & scpcr_pkg::MASK_CLK_DIV;
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // power-on initialisation busy flag
    // ------------------------------------------------------------
    // the sensor is ready once the init count has run out after reset
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            initCntQ <= 16'h0000;
            busyQ <= 1'b1;
        end
        else if (busyQ)
        begin
            initCntQ <= 16'(initCntQ + 16'h0001);
            if (initCntQ == 16'(scpcr_pkg::INIT_CYCLES - 1))
                busyQ <= 1'b0;
        end
    end

    assign initInProgress = busyQ;

    // ------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------
    // registered so every control leaves the block from a flop
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sensorSleep <= 1'b0;
            defectFixEnable <= 1'b0;
            blackCompDisable <= 1'b0;
            defectFixMonoSelect <= 1'b0;
            singleAmpRouting <= 1'b0;
            monoSensorSelect <= 1'b0;
            interlaceSelect <= 1'b0;
            horizSkipEnable <= 1'b0;
            vertSkipEnable <= 1'b0;
            syncFollowerSelect <= 1'b0;
            videoAmpOff <= 1'b0;
            colourAmpsOff <= 2'h0;
            converterOff <= 1'b0;
        end
        else
        begin
            sensorSleep <= cfg0Q[scpcr_pkg::CFG0_SLEEP] | powerDownPin;
            defectFixEnable <= cfg0Q[scpcr_pkg::CFG0_DEFECT_FIX];
            blackCompDisable <= cfg0Q[scpcr_pkg::CFG0_BLACK_OFF];
            defectFixMonoSelect <= cfg0Q[scpcr_pkg::CFG0_DEFECT_MONO];
            singleAmpRouting <= cfg0Q[scpcr_pkg::CFG0_SINGLE_AMP];
            monoSensorSelect <= cfg1Q[scpcr_pkg::CFG1_MONO];
            interlaceSelect <= cfg1Q[scpcr_pkg::CFG1_INTERLACE];
            horizSkipEnable <= cfg1Q[scpcr_pkg::CFG1_HSKIP];
            vertSkipEnable <= cfg1Q[scpcr_pkg::CFG1_VSKIP];
            syncFollowerSelect <= cfg1Q[scpcr_pkg::CFG1_FOLLOWER];
            videoAmpOff <= pwrQ[scpcr_pkg::PWR_VIDEO_AMP];
            colourAmpsOff <= pwrQ[scpcr_pkg::PWR_COLOUR_HI:scpcr_pkg::PWR_COLOUR_LO];
            converterOff <= pwrQ[scpcr_pkg::PWR_CONVERTER];
        end
    end

    // ------------------------------------------------------------
    // clock dividers
    // ------------------------------------------------------------
    // pump ratio is a power of two from the two-bit code
    assign pumpRatio = 5'h01 << clkQ[scpcr_pkg::CLK_PUMP_HI:scpcr_pkg::CLK_PUMP_LO];
    // horizontal skip halves the pixel rate; line timing is left untouched
    assign pixelRatio = horizSkipEnable ? 5'h02 : 5'h01;

    scpcr_clk_div pumpDiv
    (
        .clock(clock),
        .rst(rst),
        .tickIn(1'b1),
        .divisor(pumpRatio),
        .tickOut(pumpClockEn)
    );

    // code zero and code one both give the master rate
    scpcr_clk_div sensorDiv
    (
        .clock(clock),
        .rst(rst),
        .tickIn(1'b1),
        .divisor(clkQ[scpcr_pkg::CLK_SENSOR_HI:0]),
        .tickOut(sensorClockEn)
    );

    scpcr_clk_div pixelDiv
    (
        .clock(clock),
        .rst(rst),
        .tickIn(sensorClockEn),
        .divisor(pixelRatio),
        .tickOut(pixelClockEn)
    );

endmodule

/* File: tb/scpcr_regs_asserts.sv */
// concurrent checks on the ports of the sensor configuration register bank
`timescale 1ns/1ps
module scpcr_regs_chk
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // two-wire port and power-down pin
    input wire logic scl,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic powerDownPin,
    // watched controls
    input wire logic initInProgress,
    input wire logic sensorSleep,
    input wire logic horizSkipEnable,
    input wire logic videoAmpOff,
    input wire logic [1:0] colourAmpsOff,
    input wire logic converterOff,
    input wire logic sensorClockEn,
    input wire logic pixelClockEn
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [6:0] upCnt_q;

    // edges since reset release; saturates so a long run never wraps back into busy
    always_ff @(posedge clock)
    begin
        if (rst)
            upCnt_q <= 7'h00;
        else if (upCnt_q != 7'h7F)
            upCnt_q <= upCnt_q + 7'h01;
    end

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_first_tick;
        !sensorClockEn [*4] ##1 sensorClockEn;
    endsequence
    sequence s_plain_pulse;
        sensorClockEn && !horizSkipEnable ##1 !horizSkipEnable;
    endsequence
    sequence s_skip_pulse;
        horizSkipEnable && pixelClockEn ##1 horizSkipEnable;
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_reset_state: assert property ($fell(rst) |-> initInProgress && !sdaOe
        && !videoAmpOff && colourAmpsOff == 2'h0 && !converterOff)
        else $error("outputs wrong after reset");
    a_first_tick: assert property ($fell(rst) |-> s_first_tick)
        else $error("sensor divider does not start at four");
    a_busy_span: assert property (initInProgress == (int'(upCnt_q) < scpcr_pkg::INIT_CYCLES))
        else $error("busy flag span wrong");
    a_sleep_pin: assert property (powerDownPin |=> sensorSleep)
        else $error("pin does not sleep the sensor");
    a_ack_timing: assert property ($changed(sdaOe) |-> $past(scl, 2) && !$past(scl))
        else $error("data drive moved outside scl fall");
    a_pix_source: assert property (pixelClockEn |-> $past(sensorClockEn))
        else $error("pixel pulse without sensor pulse");
    a_pix_plain: assert property (s_plain_pulse |-> pixelClockEn)
        else $error("pixel pulse missing");
    a_pix_skip: assert property (s_skip_pulse |-> !pixelClockEn)
        else $error("pixel clock not halved");
    a_drive_low: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
endmodule

bind scpcr_regs scpcr_regs_chk chk_u (.clock(clock), .rst(rst), .scl(scl), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .powerDownPin(powerDownPin), .initInProgress(initInProgress),
    .sensorSleep(sensorSleep), .horizSkipEnable(horizSkipEnable), .videoAmpOff(videoAmpOff),
    .colourAmpsOff(colourAmpsOff), .converterOff(converterOff),
    .sensorClockEn(sensorClockEn), .pixelClockEn(pixelClockEn));

/* File: tb/scpcr_regs_test.sv */
// self-checking bench for the sensor configuration register bank
`timescale 1ns/1ps
module scpcr_regs_test;
    localparam logic [7:0] WR = {scpcr_pkg::LINK_DEVICE_ADDR, 1'b0};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic scl = 1'b1;
    logic sdaDrv = 1'b1;
    logic powerDownPin = 1'b0;
    logic sdaIn, sdaOut, sdaOe, initInProgress, sensorSleep, defectFixEnable;
    logic blackCompDisable, defectFixMonoSelect, singleAmpRouting, monoSensorSelect;
    logic interlaceSelect, horizSkipEnable, vertSkipEnable, syncFollowerSelect;
    logic videoAmpOff, converterOff, pumpClockEn, sensorClockEn, pixelClockEn;
    logic [1:0] colourAmpsOff;
    logic [7:0] adr [3] = '{8'h02, 8'h03, 8'h04};
    logic [7:0] msk [3] = '{8'h75, 8'hF4, 8'h0F};
    logic [7:0] scode [4] = '{8'h00, 8'h01, 8'h02, 8'h1F};
    int sper [4] = '{1, 1, 2, 31};
    int n_fail = 0;
    int n_checks = 0;

    // data line is wired-and with a pull-up
    assign sdaIn = sdaDrv & ~sdaOe;
    always #12.5 clock = ~clock;

    scpcr_regs dut_u (.clock, .rst, .scl, .sdaIn, .sdaOut, .sdaOe, .powerDownPin,
        .initInProgress, .sensorSleep, .defectFixEnable, .blackCompDisable,
        .defectFixMonoSelect, .singleAmpRouting, .monoSensorSelect, .interlaceSelect,
        .horizSkipEnable, .vertSkipEnable, .syncFollowerSelect, .videoAmpOff,
        .colourAmpsOff, .converterOff, .pumpClockEn, .sensorClockEn, .pixelClockEn);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic summarize();
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    // packs one register's controls at their bit positions
    function automatic logic [7:0] outs(input int r);
        case (r)
            0: return {initInProgress, sensorSleep, defectFixEnable, blackCompDisable, 1'b0,
                defectFixMonoSelect, 1'b0, singleAmpRouting};
            1: return {monoSensorSelect, interlaceSelect, horizSkipEnable, vertSkipEnable, 1'b0,
                syncFollowerSelect, 2'h0};
            default: return {4'h0, videoAmpOff, colourAmpsOff, converterOff};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // two-wire master, three clocks per scl phase
    // ----------------------------------------------------------------
    task automatic putBit(input logic b);
        sdaDrv = b;
        tick(3);
        scl = 1'b1;
        tick(3);
        scl = 1'b0;
    endtask
    task automatic getBit(output logic b);
        sdaDrv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(2);
        b = sdaIn;
        tick(1);
        scl = 1'b0;
    endtask
    task automatic putByte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            putBit(d[i]);
        getBit(a);
        ack = ~a;
    endtask
    task automatic getByte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            getBit(d[i]);
        putBit(last);
    endtask
    task automatic startCond();
        sdaDrv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b0;
    endtask
    task automatic stopCond();
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b1;
        tick(3);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
        input bit two);
        logic k0, k1, k2, k3;
        startCond();
        putByte(WR, k0);
        putByte(a, k1);
        putByte(d0, k2);
        k3 = 1'b1;
        if (two)
            putByte(d1, k3);
        stopCond();
        check("write ack", 8'h01, {7'h00, k0 & k1 & k2 & k3});
    endtask
    // pointer write, repeated start, then one or two bytes with auto-increment
    task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1,
        input bit two);
        logic k0, k1, k2;
        logic [7:0] d;
        startCond();
        putByte(WR, k0);
        putByte(a, k1);
        startCond();
        putByte(WR | 8'h01, k2);
        getByte(~two, d);
        check("read data", e0, d);
        if (two)
        begin
            getByte(1'b1, d);
            check("read next", e1, d);
        end
        stopCond();
        check("read ack", 8'h01, {7'h00, k0 & k1 & k2});
    endtask

    // ----------------------------------------------------------------
    // divider pulse spacing, bounded so a dead divider cannot hang the run
    // ----------------------------------------------------------------
    function automatic logic pick(input int s);
        case (s)
            0: return pumpClockEn;
            1: return sensorClockEn;
            default: return pixelClockEn;
        endcase
    endfunction
    task automatic gap(input int s, output int c);
        c = 0;
        do
        begin
            tick(1);
            c++;
        end
        while (pick(s) !== 1'b1 && c < 300);
        if (c >= 300)
        begin
            n_fail++;
            summarize();
        end
    endtask
    // two gaps first: a new ratio lands at the divider's wrap, or at once if below the count
    task automatic period(input int s, input int exp);
        int c;
        gap(s, c);
        gap(s, c);
        gap(s, c);
        check("divider period", exp[7:0], c[7:0]);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] b;
        logic k;
        tick(12);
        rst = 1'b0;
        tick(1);
        check("busy early", 8'h01, {7'h00, initInProgress});
        tick(45);
        check("busy done", 8'h00, {7'h00, initInProgress});
        rd(8'h02, 8'h00, 8'h00, 1'b1);
        rd(8'h04, 8'h00, 8'h04, 1'b1);
        for (int r = 0; r < 3; r++)
            for (int i = 0; i < 9; i++)
            begin
                b = (i == 8) ? 8'hFF : 8'h01 << i;
                wr(adr[r], b, 8'h00, 1'b0);
                check("controls", b & msk[r], outs(r));
                rd(adr[r], b & msk[r], 8'h00, 1'b0);
            end
        wr(8'h02, 8'h00, 8'h00, 1'b1);
        rd(8'h02, 8'h00, 8'h00, 1'b1);
        powerDownPin = 1'b1;
        tick(2);
        check("pin sleep", 8'h40, outs(0));
        powerDownPin = 1'b0;
        tick(2);
        check("pin wake", 8'h00, outs(0));
        wr(8'h30, 8'hAA, 8'h00, 1'b0);
        rd(8'h30, 8'h00, 8'h00, 1'b0);
        // a foreign device address is not acked and the bytes after it are ignored
        startCond();
        putByte(WR ^ 8'h02, k);
        check("foreign ack", 8'h00, {7'h00, k});
        putByte(8'h03, k);
        putByte(8'hFF, k);
        stopCond();
        rd(8'h03, 8'h00, 8'h00, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            b = {k[1:0], 6'h03};
            wr(8'h05, b, 8'h00, 1'b0);
            period(0, 1 << k);
        end
        period(1, 3);
        foreach (scode[j])
        begin
            wr(8'h05, scode[j], 8'h00, 1'b0);
            period(1, sper[j]);
            period(2, sper[j]);
        end
        wr(8'h03, 8'h20, 8'h00, 1'b0);
        period(2, 62);
        wr(8'h05, 8'hFF, 8'h00, 1'b0);
        rd(8'h05, 8'hDF, 8'h00, 1'b0);
        // second reset in mid-run must restore defaults and rerun init
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        check("busy again", 8'h01, {7'h00, initInProgress});
        tick(45);
        rd(8'h03, 8'h00, 8'h00, 1'b1);
        rd(8'h05, 8'h04, 8'h00, 1'b0);
        summarize();
    end
endmodule
